/* File: rtl/iam_consts.vh */
/*
  constants for the indicator assignment mux: source indices, lamp count,
  register offsets, reset assignments and timing figures.
  assumes a 100 MHz system clock and a 32-bit ahb-lite register bus.
*/
`ifndef IAM_CONSTS_VH
`define IAM_CONSTS_VH
// ************************************************************
// source indices
// ************************************************************
`define IAM_SRC_OFF        6'h00
`define IAM_SRC_ON         6'h01
`define IAM_SRC_TASK0      6'h02
`define IAM_SRC_REDUCED    6'h0C
`define IAM_SRC_LATE_ENC   6'h0D
`define IAM_SRC_LATE_DEC   6'h0E
`define IAM_SRC_SPARE      6'h0F
`define IAM_SRC_PORT0      6'h10
`define IAM_SRC_PEAK_LAT   6'h20
`define IAM_SRC_ANY_PEAK   6'h21
`define IAM_SRC_ANY_ACT    6'h22
`define IAM_SRC_VOICE      6'h23
`define IAM_SRC_RUN        6'h24
`define IAM_SRC_ERR        6'h25
`define IAM_NUM_SRC        40
`define IAM_NUM_LAMP       6
`define IAM_NUM_TASK       10
`define IAM_NUM_PORTEV     16
// ************************************************************
// register offsets (byte addresses)
// ************************************************************
`define IAM_REG_ASSIGN0    8'h00
`define IAM_REG_ASSIGN1    8'h04
`define IAM_REG_CTRL       8'h08
`define IAM_REG_STATUS     8'h0C
`define IAM_REG_IRQ_STAT   8'h10
`define IAM_REG_IRQ_MASK   8'h14
`define IAM_REG_FRAME      8'h18
`define IAM_REG_LAMPS      8'h1C
`define IAM_CTRL_SAVE_BIT  0
`define IAM_CTRL_CLRL_BIT  1
// ************************************************************
// reset values and timing
// ************************************************************
`define IAM_RST_ASSIGN0    32'h00021842
`define IAM_RST_FRAME      16'h00A0
`define IAM_WINK_MS        100
`define IAM_CLK_MHZ        100
`define IAM_WINK_CYCLES    (`IAM_WINK_MS * 1000 * `IAM_CLK_MHZ)
`define IAM_RUN_BASE       32'd10000000
`define IAM_RUN_STEP       32'd39062
`endif

/* File: rtl/iam_wink.v */
/*
  one-shot stretcher: a pulse lights the output for a fixed count.
  assumes the trigger is synchronous to clock_in.
*/
`include "iam_consts.vh"
module iam_wink #(
  parameter WINK_CYCLES = `IAM_WINK_CYCLES  // stretch length in cycles
) (
  input  wire clock_in,   // system clock
  input  wire rst_n_in,   // sync reset, active low
  input  wire trig_in,    // event pulse
  output reg  lit_out     // stretched lamp level
);
  reg [23:0] count;       // cycles left lit

  // ************************************************************
  // retrigger restarts the full interval
  // ************************************************************
  always @(posedge clock_in)
  begin
    if (!rst_n_in)
    begin
      count   <= 24'h000000;
      lit_out <= 1'b0;
    end
    else if (trig_in)
    begin
      count   <= WINK_CYCLES[23:0] - 24'h000001;
      lit_out <= 1'b1;
    end
    else if (count != 24'h000000)
    begin
      count   <= count - 24'h000001;
      lit_out <= 1'b1;
    end
    else
    begin
      lit_out <= 1'b0;
    end
  end
endmodule // iam_wink

/* File: rtl/iam_top.v */
/*
  indicator assignment mux: forty virtual sources onto six lamps, with an
  ahb-lite slave for assignment, status, interrupt and save control.
  assumes one 100 MHz clock; detector strobes are synchronous one-cycle
  pulses; task levels are synchronous; mode and condition levels come from pins.
*/
// Added by the designer: the placing of the registers and the AHB-Lite interface to the registers.
`include "iam_consts.vh"
module iam_top #(
  parameter WINK_CYCLES = `IAM_WINK_CYCLES  // wink length, shorten in sim
) (
  input  wire        clock_in,        // system clock
  input  wire        rst_n_in,        // sync reset, active low
  input  wire        hsel_in,         // ahb select
  input  wire [7:0]  haddr_in,        // ahb address
  input  wire [1:0]  htrans_in,       // ahb transfer type
  input  wire        hwrite_in,       // ahb write
  input  wire [2:0]  hsize_in,        // ahb size
  input  wire [31:0] hwdata_in,       // ahb write data
  input  wire        hready_in,       // ahb bus ready
  output wire [31:0] hrdata_out,      // ahb read data
  output wire        hreadyout_out,   // ahb ready out
  output wire        hresp_out,       // ahb response
  input  wire [15:0] peak_ev_in,      // per-port peak pulses
  input  wire [15:0] act_ev_in,       // per-port activity pulses
  input  wire        tone_peak_in,    // tone port peak pulse
  input  wire        tone_act_in,     // tone port activity pulse
  input  wire [9:0]  task_busy_in,    // task execution levels
  input  wire        reduced_rate_timing_in, // reduced timing mode pin
  input  wire        enc_voice_in,    // voice at encoder
  input  wire        enc_run_in,      // encoder running
  input  wire        dec_voice_in,    // voice at decoder
  input  wire        dec_run_in,      // decoder running
  input  wire [6:0]  cpu_load_in,     // processor load, 0 to 127
  input  wire        err_cond_in,     // error condition pin
  input  wire        slip_ev_in,      // sample/packet slip pulse
  input  wire        enc_frame_ev_in, // encoder frame end pulse
  input  wire [15:0] enc_frame_len_in,// encoder frame length
  input  wire        dec_frame_ev_in, // decoder frame end pulse
  input  wire [15:0] dec_frame_len_in,// decoder frame length
  input  wire        nv_valid_in,     // stored table present
  input  wire [35:0] nv_table_in,     // stored table
  output reg         nv_save_out,     // save strobe to storage
  output reg  [35:0] nv_table_out,    // table to store
  output reg  [5:0]  lamp_out,        // physical lamps
  output wire        irq_out          // level interrupt
);
  // ************************************************************
  // pin synchronisers: 3 flops, change when 2nd and 3rd agree
  // ************************************************************
  // the agreement test keeps a one-cycle glitch in the chain off the lamps
  reg [2:0] sy_mode;      // reduced timing chain
  reg [2:0] sy_err;       // error condition chain
  reg       mode_q;       // filtered mode level
  reg       err_q;        // filtered error level
  always @(posedge clock_in)
  begin
    if (!rst_n_in)
    begin
      sy_mode <= 3'h0;
      sy_err  <= 3'h0;
      mode_q  <= 1'b0;
      err_q   <= 1'b0;
    end
    else
    begin
      sy_mode <= {sy_mode[1:0], reduced_rate_timing_in};
      sy_err  <= {sy_err[1:0], err_cond_in};
      if (sy_mode[1] == sy_mode[2])
        mode_q <= sy_mode[2];
      if (sy_err[1] == sy_err[2])
        err_q <= sy_err[2];
    end
  end

  // ************************************************************
  // registers
  // ************************************************************
  reg [5:0]  assign_tab [0:5];   // per-lamp source index
  reg [15:0] frame_len;          // configured_frame_length
  reg        peak_latched;       // any_port_peak_latched
  reg [3:0]  irq_stat;           // sticky: peak, late enc, late dec, slip
  reg [3:0]  irq_mask;           // interrupt enables
  reg        restored;           // storage load done
  reg        ap_valid;           // data phase pending
  reg        ap_write;           // pending is a write
  reg [7:0]  ap_addr;            // pending address
  reg [31:0] rdata;              // read data
  // one loop variable per process, so no two processes drive the same one
  integer    i;                  // loop index, source vector only
  integer    j;                  // loop index, lamp mux only
  integer    k;                  // loop index, bus slave only

  // any-port events: every mixer port, spares included, and the tone port
  wire any_peak = (|peak_ev_in) | tone_peak_in;
  wire any_act  = (|act_ev_in) | tone_act_in;
  wire late_enc = enc_frame_ev_in & (enc_frame_len_in > frame_len);
  wire late_dec = dec_frame_ev_in & (dec_frame_len_in > frame_len);
  wire ahb_go   = hsel_in & hready_in & htrans_in[1];
  wire wr_ctrl  = ap_valid & ap_write & (ap_addr == `IAM_REG_CTRL);
  wire [3:0] irq_ev = {slip_ev_in, late_dec, late_enc, any_peak};
  // write-one-to-clear mask, live only in the data phase of a status write
  wire [3:0] w1c = (ap_valid & ap_write & (ap_addr == `IAM_REG_IRQ_STAT))
                   ? hwdata_in[3:0] : 4'h0;

  // ************************************************************
  // wink stretchers for dynamic sources
  // ************************************************************
  // slot map: 2..0 idle, 10..3 per-port peaks, 18..11 per-port activity,
  // 30..19 spare, 31 late enc, 32 late dec, 33 any peak, 34 any act, 35 slip.
  // spare ports only reach the any-port winks; their slots never trigger,
  // which keeps slot 3+n lined up with source index 0x10+n
  wire [35:0] wk_trig = {slip_ev_in, any_act, any_peak, late_dec, late_enc,
                         12'h000,
                         act_ev_in[7:0], peak_ev_in[7:0], 3'h0};
  wire [35:0] wk_lit;             // stretched levels
  genvar g;
  generate
    for (g = 3; g < 36; g = g + 1)
    begin : g_wink
      iam_wink #(.WINK_CYCLES(WINK_CYCLES)) u_wink (
        .clock_in (clock_in),
        .rst_n_in (rst_n_in),
        .trig_in  (wk_trig[g]),
        .lit_out  (wk_lit[g])
      );
    end
  endgenerate
  assign wk_lit[2:0] = 3'h0;

  // ************************************************************
  // run blinker: half period grows with load
  // ************************************************************
  reg [31:0] run_cnt;            // half period counter
  reg        run_lit;            // blink level
  // load only stretches the half period; the run lamp never stops blinking
  wire [31:0] run_half = `IAM_RUN_BASE + `IAM_RUN_STEP * {25'h0, cpu_load_in};
  always @(posedge clock_in)
  begin
    if (!rst_n_in)
    begin
      run_cnt <= 32'h00000000;
      run_lit <= 1'b0;
    end
    else if (run_cnt >= run_half)
    begin
      run_cnt <= 32'h00000000;
      run_lit <= ~run_lit;
    end
    else
      run_cnt <= run_cnt + 32'h00000001;
  end

  // ************************************************************
  // source vector, forty entries
  // ************************************************************
  reg [39:0] src;                // virtual indicator sources
  // purely combinational; the lamp mux flops it, so glitches never reach a pin
  always @*
  begin
    src = 40'h0000000000;
    src[`IAM_SRC_OFF]  = 1'b0;
    src[`IAM_SRC_ON]   = 1'b1;
    for (i = 0; i < `IAM_NUM_TASK; i = i + 1)
      src[`IAM_SRC_TASK0 + i] = task_busy_in[i];
    src[`IAM_SRC_REDUCED]  = mode_q;
    src[`IAM_SRC_LATE_ENC] = wk_lit[31];
    src[`IAM_SRC_LATE_DEC] = wk_lit[32];
    src[`IAM_SRC_SPARE]    = 1'b0;
    for (i = 0; i < `IAM_NUM_PORTEV; i = i + 1)
      src[`IAM_SRC_PORT0 + i] = wk_lit[3 + i];
    src[`IAM_SRC_PEAK_LAT] = peak_latched;
    src[`IAM_SRC_ANY_PEAK] = wk_lit[33];
    src[`IAM_SRC_ANY_ACT]  = wk_lit[34];
    src[`IAM_SRC_VOICE] = (enc_voice_in & enc_run_in) |
                          (dec_voice_in & dec_run_in);
    src[`IAM_SRC_RUN] = run_lit;
    src[`IAM_SRC_ERR] = err_q | wk_lit[35];
  end

  // ************************************************************
  // lamp mux, registered
  // ************************************************************
  // pick one source bit; indices past the last defined source read dark,
  // so a corrupt stored table can never light a lamp by accident
  function iam_pick;
    input [5:0]  sel;            // assigned source index
    input [39:0] vec;            // all source levels
    begin
      if (sel < `IAM_NUM_SRC)
        iam_pick = vec[sel];
      else
        iam_pick = 1'b0;
    end
  endfunction

  // registered so a mux change never shows a half-switched lamp
  always @(posedge clock_in)
  begin
    if (!rst_n_in)
      lamp_out <= 6'h00;
    else
      for (j = 0; j < `IAM_NUM_LAMP; j = j + 1)
        lamp_out[j] <= iam_pick(assign_tab[j], src);
  end

  // ************************************************************
  // bus slave and table state; zero wait, always okay
  // ************************************************************
  always @(posedge clock_in)
  begin
    if (!rst_n_in)
    begin
      assign_tab[0] <= `IAM_SRC_ANY_PEAK;
      assign_tab[1] <= `IAM_SRC_ANY_ACT;
      for (k = 2; k < `IAM_NUM_LAMP; k = k + 1)
        assign_tab[k] <= `IAM_SRC_OFF;
      frame_len    <= `IAM_RST_FRAME;
      peak_latched <= 1'b0;
      irq_stat     <= 4'h0;
      irq_mask     <= 4'h0;
      restored     <= 1'b0;
      ap_valid     <= 1'b0;
      ap_write     <= 1'b0;
      ap_addr      <= 8'h00;
      nv_save_out  <= 1'b0;
      nv_table_out <= 36'h000000000;
    end
    else
    begin
      ap_valid    <= ahb_go;
      ap_write    <= hwrite_in;
      ap_addr     <= haddr_in;
      nv_save_out <= 1'b0;
      // set wins over clear for every sticky bit
      irq_stat <= (irq_stat & ~w1c) | irq_ev;
      // latched peak: set wins over software clear
      if (any_peak)
        peak_latched <= 1'b1;
      else if (wr_ctrl & hwdata_in[`IAM_CTRL_CLRL_BIT])
        peak_latched <= 1'b0;
      // first edge after reset: take the stored table once, if there is one
      if (!restored)
      begin
        restored <= 1'b1;
        if (nv_valid_in)
          for (k = 0; k < `IAM_NUM_LAMP; k = k + 1)
            assign_tab[k] <= nv_table_in[6*k +: 6];
      end
      if (ap_valid & ap_write)
      begin
        case (ap_addr)
          `IAM_REG_ASSIGN0:
            for (k = 0; k < 4; k = k + 1)
              assign_tab[k] <= hwdata_in[8*k +: 6];
          `IAM_REG_ASSIGN1:
          begin
            assign_tab[4] <= hwdata_in[5:0];
            assign_tab[5] <= hwdata_in[13:8];
          end
          `IAM_REG_CTRL:
            if (hwdata_in[`IAM_CTRL_SAVE_BIT])
            begin
              nv_save_out <= 1'b1;
              for (k = 0; k < `IAM_NUM_LAMP; k = k + 1)
                nv_table_out[6*k +: 6] <= assign_tab[k];
            end
          `IAM_REG_IRQ_MASK: irq_mask  <= hwdata_in[3:0];
          `IAM_REG_FRAME:    frame_len <= hwdata_in[15:0];
          default: ;
        endcase
      end
    end
  end

  // ************************************************************
  // read data, from flops in the data phase
  // ************************************************************
  // captured at the address phase so hrdata comes from a flop; the price is
  // that a read right behind a write to the same register sees the old value
  always @(posedge clock_in)
  begin
    if (!rst_n_in)
      rdata <= 32'h00000000;
    else if (ahb_go & ~hwrite_in)
      case (haddr_in)
        `IAM_REG_ASSIGN0: rdata <= {2'h0, assign_tab[3], 2'h0, assign_tab[2],
                                    2'h0, assign_tab[1], 2'h0, assign_tab[0]};
        `IAM_REG_ASSIGN1: rdata <= {18'h0, assign_tab[5], 2'h0, assign_tab[4]};
        `IAM_REG_STATUS:  rdata <= {28'h0, err_q, mode_q, restored, peak_latched};
        `IAM_REG_IRQ_STAT: rdata <= {28'h0, irq_stat};
        `IAM_REG_IRQ_MASK: rdata <= {28'h0, irq_mask};
        `IAM_REG_FRAME:   rdata <= {16'h0, frame_len};
        `IAM_REG_LAMPS:   rdata <= {26'h0, lamp_out};
        default:          rdata <= 32'h00000000;
      endcase
  end

  // ************************************************************
  // bus handshake and interrupt level
  // ************************************************************
  // no wait states and no error response: every register is one flop away
  assign hrdata_out    = rdata;
  assign hreadyout_out = 1'b1;
  assign hresp_out     = 1'b0;
  assign irq_out       = |(irq_stat & irq_mask);
endmodule // iam_top

/* File: tb/iam_nv_model.sv */
/*
  nonvolatile store model: keeps the lamp table on each save strobe and
  offers it back at start-up. assumes one clock and a one-cycle strobe.
*/
module iam_nv_model (
  input  wire        clock_in,   // system clock
  input  wire        save_in,    // save strobe from the block
  input  wire [35:0] table_in,   // table to keep
  output reg         valid_out,  // a table is stored
  output reg  [35:0] table_out   // stored table
);
  timeunit 1ns;
  timeprecision 1ps;
  // empty store: all-ones pattern, so a wrong restore cannot look plausible
  initial
  begin
    valid_out = 1'h0;
    table_out = 36'hFFFFFFFFF;
  end
  // capture on the strobe; contents survive a reset of the block
  always @(posedge clock_in)
  begin
    if (save_in)
    begin
      valid_out <= 1'h1;
      table_out <= table_in;
    end
  end
endmodule // iam_nv_model

/* File: tb/iam_top_monitor.sv */
/*
  checker for the lamp mux: follows the source of lamp zero and watches
  lamps and the save strobe. assumes only the top's ports; bound below.
*/
`include "iam_consts.vh"
module iam_mon #(
  parameter WINK_CYCLES = 20  // wink length, as on the top
) (
  input wire        clock_in,      // clock
  input wire        rst_n_in,      // sync reset
  input wire        hsel_in,       // bus select
  input wire [7:0]  haddr_in,      // bus address
  input wire [1:0]  htrans_in,     // bus transfer
  input wire        hwrite_in,     // bus write
  input wire [31:0] hwdata_in,     // bus write data
  input wire        hready_in,     // bus ready
  input wire [15:0] peak_ev_in,    // peak pulses
  input wire        tone_peak_in,  // tone peak pulse
  input wire [9:0]  task_busy_in,  // task levels
  input wire        enc_voice_in,  // encoder voice
  input wire        enc_run_in,    // encoder running
  input wire        dec_voice_in,  // decoder voice
  input wire        dec_run_in,    // decoder running
  input wire        nv_valid_in,   // stored table present
  input wire [35:0] nv_table_in,   // stored table
  input wire        nv_save_out,   // save strobe
  input wire [35:0] nv_table_out,  // table to store
  input wire [5:0]  lamp_out,      // lamps
  input wire        irq_out        // interrupt
);
  timeunit 1ns;
  timeprecision 1ps;
  // ************************************************************
  // lamp zero source tracking
  // ************************************************************
  reg       wr_d;   // write data phase in progress
  reg [7:0] wa_d;   // its address
  reg       rst_q;  // reset level one edge ago
  reg [5:0] sel0;   // source now on lamp zero
  int       lit_run;  // cycles lamp zero has shown the any-peak wink
  wire      vo = (enc_voice_in & enc_run_in) | (dec_voice_in & dec_run_in);  // voice level
  // updates at the same edge as the slave's table, so |=> lines up
  always @(posedge clock_in)
  begin
    rst_q <= rst_n_in;
    wr_d  <= hsel_in & hready_in & htrans_in[1] & hwrite_in & rst_n_in;
    wa_d  <= haddr_in;
    if (!rst_n_in)
      sel0 <= `IAM_SRC_ANY_PEAK;  // reset default
    else if (!rst_q && nv_valid_in)
      sel0 <= nv_table_in[5:0];   // restore edge
    else if (wr_d && wa_d == `IAM_REG_ASSIGN0)
      sel0 <= hwdata_in[5:0];     // software write
  end
  // wink length on lamp zero; restarts on each peak so a retrigger is fine
  always @(posedge clock_in)
  begin
    if (!rst_n_in || |peak_ev_in || tone_peak_in
        || sel0 != `IAM_SRC_ANY_PEAK || !lamp_out[0])
      lit_run <= 0;
    else
      lit_run <= lit_run + 1;
  end
  // ************************************************************
  // properties
  // ************************************************************
  default clocking dc @(posedge clock_in);
  endclocking
  default disable iff (!rst_n_in);
  sequence peak_seen;
    sel0 == `IAM_SRC_ANY_PEAK && (|peak_ev_in || tone_peak_in);
  endsequence
  sequence wink_lit;
    ##2 lamp_out[0] [*6];
  endsequence
  lamp_reset_a: assert property ($rose(rst_n_in) |-> lamp_out == 6'h00 && !irq_out)
    else $error("lamps or interrupt lit after reset");
  const_on_a: assert property (sel0 == `IAM_SRC_ON |=> lamp_out[0])
    else $error("constant on source left lamp dark");
  dark_source_a: assert property ((sel0 == `IAM_SRC_OFF || sel0 == `IAM_SRC_SPARE
    || sel0 >= 6'h28) |=> !lamp_out[0]) else $error("dark source lit lamp");
  voice_follow_a: assert property (sel0 == `IAM_SRC_VOICE |=> lamp_out[0] == $past(vo))
    else $error("voice lamp wrong");
  task_follow_a: assert property (sel0 == 6'h0B && (&task_busy_in || ~|task_busy_in)
    |=> lamp_out[0] == $past(task_busy_in[9])) else $error("task lamp wrong");
  peak_wink_a: assert property (peak_seen |-> wink_lit)
    else $error("peak wink too short");
  latch_hold_a: assert property (sel0 == `IAM_SRC_PEAK_LAT && $stable(sel0)
    && lamp_out[0] && !wr_d && !$past(wr_d) |=> lamp_out[0]) else $error("latch dropped");
  // two cycles of slack: the lit run starts one edge after the peak, and one
  // more if the old source was lit when lamp zero was switched over
  wink_end_a: assert property (lit_run <= WINK_CYCLES + 2)
    else $error("peak wink never ended");
  save_pulse_a: assert property (nv_save_out |=> !nv_save_out)
    else $error("save strobe longer than one cycle");
  save_table_a: assert property (nv_save_out |-> nv_table_out[5:0] == sel0)
    else $error("saved table differs");
endmodule // iam_mon
bind iam_top iam_mon #(.WINK_CYCLES(WINK_CYCLES)) u_mon (
  .clock_in(clock_in), .rst_n_in(rst_n_in), .hsel_in(hsel_in), .haddr_in(haddr_in),
  .htrans_in(htrans_in), .hwrite_in(hwrite_in), .hwdata_in(hwdata_in), .hready_in(hready_in),
  .peak_ev_in(peak_ev_in), .tone_peak_in(tone_peak_in), .task_busy_in(task_busy_in),
  .enc_voice_in(enc_voice_in), .enc_run_in(enc_run_in), .dec_voice_in(dec_voice_in),
  .dec_run_in(dec_run_in), .nv_valid_in(nv_valid_in), .nv_table_in(nv_table_in),
  .nv_save_out(nv_save_out), .nv_table_out(nv_table_out), .lamp_out(lamp_out),
  .irq_out(irq_out));

/* File: tb/iam_top_tb_top.sv */
/*
  testbench for the lamp mux: bus tasks, event pulses and lamp compares.
  assumes a zero-wait slave and the nonvolatile store model beside it.
*/
`include "iam_consts.vh"
module iam_top_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int          WINK = 20;  // shortened wink
  localparam logic [35:0] LIST = {6'h00, 6'h3F, 6'h0F, 6'h23, 6'h0B, 6'h01};  // lamp zero sources
  logic        clk = 1'h0, rst_n = 1'h0, hsel = 1'h0, hwrite = 1'h0;
  logic        hrdy, hresp, irq, nv_save, nv_valid, irq_a;
  logic [7:0]  haddr = 8'h00;
  logic [1:0]  htrans = 2'h0;
  logic [31:0] hwdata = 32'h0, hrdata, rd;
  logic [15:0] peak = 16'h0, act = 16'h0, elen = 16'h0, dlen = 16'h0;
  logic        tpk = 1'h0, red = 1'h0, ev = 1'h0, er = 1'h0, dv = 1'h0, dr = 1'h0;
  logic        err = 1'h0, slip = 1'h0, efr = 1'h0, dfr = 1'h0;
  logic [9:0]  busy = 10'h0;
  logic [35:0] nv_tab, nv_keep;
  logic [5:0]  lamp;
  int          bad_count = 0, n_compared = 0;
  always #5 clk = ~clk;
  iam_top #(.WINK_CYCLES(WINK)) u_dut (
    .clock_in(clk), .rst_n_in(rst_n), .hsel_in(hsel), .haddr_in(haddr),
    .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(3'h2), .hwdata_in(hwdata),
    .hready_in(hrdy), .hrdata_out(hrdata), .hreadyout_out(hrdy), .hresp_out(hresp),
    .peak_ev_in(peak), .act_ev_in(act), .tone_peak_in(tpk), .tone_act_in(1'h0),
    .task_busy_in(busy), .reduced_rate_timing_in(red), .enc_voice_in(ev),
    .enc_run_in(er), .dec_voice_in(dv), .dec_run_in(dr), .cpu_load_in(7'h00),
    .err_cond_in(err), .slip_ev_in(slip), .enc_frame_ev_in(efr),
    .enc_frame_len_in(elen), .dec_frame_ev_in(dfr), .dec_frame_len_in(dlen),
    .nv_valid_in(nv_valid), .nv_table_in(nv_tab), .nv_save_out(nv_save),
    .nv_table_out(nv_keep), .lamp_out(lamp), .irq_out(irq));
  iam_nv_model u_nv (.clock_in(clk), .save_in(nv_save), .table_in(nv_keep),
    .valid_out(nv_valid), .table_out(nv_tab));
  // ************************************************************
  // tasks
  // ************************************************************
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic wrap_up;
    $display("compares %0d, mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic cmp(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp)
    begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // one edge, then more while the slave stalls; bounded so a hang ends the run
  task automatic rdy_wait;
    int n;
    n = 0;
    tick(1);
    while (hrdy !== 1'h1)
    begin
      n++;
      if (n > 20)
      begin
        bad_count++;
        wrap_up();
      end
      tick(1);
    end
  endtask
  // single word transfer: address phase, then data phase; read data lands in rd
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'h1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    rdy_wait();
    hsel <= 1'h0;
    htrans <= 2'h0;
    hwdata <= d;
    rdy_wait();
    rd = hrdata;
  endtask
  // ************************************************************
  // scenarios
  // ************************************************************
  initial
  begin
    tick(5);
    rst_n <= 1'h1;
    tick(1);
    tpk <= 1'h1;
    tick(1);
    tpk <= 1'h0;
    act <= 16'h0200;
    tick(1);
    act <= 16'h0000;
    tick(2);
    cmp("default lamps", 32'h3, {26'h0, lamp});
    tick(WINK - 6);
    cmp("wink held", 32'h3, {26'h0, lamp});
    tick(8);
    cmp("wink over", 32'h0, {26'h0, lamp});
    bus(1'h1, `IAM_REG_ASSIGN0, 32'h0F0C0001);
    bus(1'h1, `IAM_REG_ASSIGN1, 32'h00002328);
    red <= 1'h1;
    ev <= 1'h1;
    er <= 1'h1;
    tick(8);
    cmp("static lamps", 32'h25, {26'h0, lamp});
    bus(1'h1, `IAM_REG_ASSIGN0, 32'h0E0D1320);
    bus(1'h1, `IAM_REG_ASSIGN1, 32'h00000B25);
    bus(1'h1, `IAM_REG_CTRL, 32'h2);
    tick(3);
    cmp("latch cleared", 32'h0, {26'h0, lamp});
    peak <= 16'h0004;
    tick(1);
    peak <= 16'h0008;
    tick(1);
    peak <= 16'h0000;
    tick(3);
    cmp("port peaks", 32'h3, {26'h0, lamp});
    tick(WINK + 4);
    cmp("latch held", 32'h1, {26'h0, lamp});
    bus(1'h0, `IAM_REG_IRQ_STAT, 32'h0);
    cmp("irq status", 32'h1, rd);
    bus(1'h1, `IAM_REG_IRQ_MASK, 32'h0);
    tick(1);
    irq_a = irq;
    bus(1'h1, `IAM_REG_IRQ_MASK, 32'hF);
    tick(1);
    cmp("irq masking", 32'h1, {31'h0, irq_a ^ irq});
    bus(1'h1, `IAM_REG_IRQ_STAT, 32'h1);
    tick(1);
    cmp("irq cleared", 32'h0, {31'h0, irq});
    bus(1'h1, `IAM_REG_FRAME, 32'h10);
    elen <= 16'h0010;
    dlen <= 16'h0011;
    efr <= 1'h1;
    dfr <= 1'h1;
    tick(1);
    efr <= 1'h0;
    dfr <= 1'h0;
    elen <= 16'h0011;
    tick(3);
    cmp("late dec only", 32'h9, {26'h0, lamp});
    efr <= 1'h1;
    tick(1);
    efr <= 1'h0;
    tick(3);
    cmp("late enc", 32'hD, {26'h0, lamp});
    slip <= 1'h1;
    tick(1);
    slip <= 1'h0;
    tick(3);
    cmp("slip wink", 32'h1D, {26'h0, lamp});
    tick(WINK + 4);
    err <= 1'h1;
    busy <= 10'h200;
    tick(8);
    cmp("error and task", 32'h31, {26'h0, lamp});
    bus(1'h0, `IAM_REG_STATUS, 32'h0);
    cmp("status", 32'hF, rd);
    bus(1'h0, `IAM_REG_LAMPS, 32'h0);
    cmp("lamp readback", 32'h31, rd);
    bus(1'h0, 8'h40, 32'h0);
    cmp("unmapped read", 32'h0, rd);
    cmp("okay response", 32'h0, {31'h0, hresp});
    bus(1'h1, `IAM_REG_CTRL, 32'h1);
    tick(3);
    rst_n <= 1'h0;
    tick(5);
    rst_n <= 1'h1;
    tick(1);
    bus(1'h0, `IAM_REG_ASSIGN0, 32'h0);
    cmp("restored table", 32'h0E0D1320, rd);
    busy <= 10'h3FF;
    ev <= 1'h0;
    dv <= 1'h1;
    dr <= 1'h1;
    for (int i = 0; i < 6; i++)
    begin
      bus(1'h1, `IAM_REG_ASSIGN0, {26'h0, LIST[i*6 +: 6]});
      tick(3);
      cmp("lamp zero", {31'h0, i < 3}, {31'h0, lamp[0]});
    end
    wrap_up();
  end
  // watchdog: a hang counts as a mismatch
  initial
  begin
    tick(20000);
    bad_count++;
    wrap_up();
  end
endmodule // iam_top_tb_top
